/* core/stxf_core.sv */
// stxf_core: transmit holding buffer, frame format register and transmit shifter.
// assumes the cpu access port and serial clock enable are synchronous to i_clk.
`timescale 1ns/1ps

// Notes on behaviour
// R1: when shifter empty, load holding buffer into shifter and start sending
// R2: next byte may be written while current one shifts out
// R3: holding buffer is 8 bits, readable and writable any time
// R4: holding buffer resets to all ones
// R5: format register is 8 bits, read/write any time, resets to zero
// R6: mode bit: 0 asynchronous, 1 clocked synchronous
// R7: async length bit selects 8 or 7 bits; sync always 8
// R8: with 7-bit characters the buffer msb is not sent
// R9: parity enable only in async mode; none in sync mode
// R10: parity sense 0 even, 1 odd over character plus parity
// R11: parity sense ignored unless async with parity enabled
// R12: async adds one or two stop ones; sync adds none
// R13: receiver checks only first stop bit; second zero is next start
// R14: multiprocessor format in async mode overrides parity settings
// R15: clock select picks peripheral clock divided by 1, 4, 16 or 64
// R16: data leaves least significant bit first
// R17: no load into shifter while empty flag is set
// R18: async frame: start zero, data, parity or mp bit, stops
module stxf_core
    import stxf_pkg::*;
(
    // clock, reset, enable
    input  wire logic          i_clk,
    input  wire logic          i_srst,
    input  wire logic          i_ce,
    // cpu register port
    input  wire stxf_cpu_req_t i_cpu,
    input  wire logic          i_clear_empty,
    input  wire logic          i_tx_enable,
    input  wire logic          i_mp_bit,
    input  wire logic [7:0]    i_bit_ticks,
    output logic [7:0]         o_hold_rdata,
    output logic [7:0]         o_fmt_rdata,
    // status
    output logic               o_empty_flag,
    output logic               o_tx_busy,
    output logic               o_baud_tick,
    // serial line
    output logic               o_txd,
    output logic               o_sclk
);

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [7:0]  hold_reg;
    logic [7:0]  fmt_reg;
    logic        empty_reg;
    stxf_fmt_t   fmt;
    stxf_state_t state_reg;
    logic [7:0]  shift_reg;
    logic [3:0]  bitcnt_reg;
    logic [1:0]  stopcnt_reg;
    logic [7:0]  ticks_reg;
    logic        extra_reg;
    logic        pre_tick;
    logic        bit_end;
    logic        load;

    assign fmt = stxf_fmt_t'(fmt_reg);

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            hold_reg <= STXF_HOLD_RST;  // R4
        end else if (i_ce && i_cpu.wr && i_cpu.sel == STXF_SEL_HOLD) begin
            hold_reg <= i_cpu.wdata;  // R3
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            fmt_reg <= STXF_FMT_RST;  // R5
        end else if (i_ce && i_cpu.wr && i_cpu.sel == STXF_SEL_FORMAT) begin
            fmt_reg <= i_cpu.wdata;  // R5
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_hold_rdata <= STXF_HOLD_RST;
            o_fmt_rdata  <= STXF_FMT_RST;
        end else if (i_ce) begin
            o_hold_rdata <= hold_reg;  // R3
            o_fmt_rdata  <= fmt_reg;
        end
    end

    // ------------------------------------------------------------------
    // empty flag: loading or transmit disable sets it, cpu clears it; set wins
    // ------------------------------------------------------------------
    assign load = (state_reg == STXF_IDLE) && !empty_reg && i_tx_enable;  // R1 R17

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            empty_reg <= 1'b1;
        end else if (i_ce) begin
            if (load || !i_tx_enable) begin
                empty_reg <= 1'b1;
            end else if (i_clear_empty) begin
                empty_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_empty_flag <= 1'b1;
            o_tx_busy    <= 1'b0;
        end else if (i_ce) begin
            o_empty_flag <= empty_reg;
            o_tx_busy    <= state_reg != STXF_IDLE;  // R2
        end
    end

    // ------------------------------------------------------------------
    // baud tick: prescaler then bit-time counter
    // ------------------------------------------------------------------
    stxf_prescaler u_pre (
        .i_clk  (i_clk),
        .i_srst (i_srst),
        .i_ce   (i_ce),
        .i_cks  (fmt.cks),
        .o_tick (pre_tick)
    );

    assign bit_end = pre_tick && (ticks_reg >= i_bit_ticks);

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ticks_reg   <= 8'h00;
            o_baud_tick <= 1'b0;
        end else if (i_ce) begin
            o_baud_tick <= bit_end;
            if (load) begin
                ticks_reg <= 8'h00;
            end else if (bit_end) begin
                ticks_reg <= 8'h00;
            end else if (pre_tick) begin
                ticks_reg <= ticks_reg + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------------
    // transmit shifter
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state_reg   <= STXF_IDLE;
            shift_reg   <= 8'h00;
            bitcnt_reg  <= 4'h0;
            stopcnt_reg <= 2'h0;
            extra_reg   <= 1'b0;
        end else if (i_ce) begin
            case (state_reg)
                STXF_IDLE: begin
                    if (load) begin
                        shift_reg <= hold_reg;  // R1
                        if (fmt.sync_mode || !fmt.chr7) begin
                            bitcnt_reg <= STXF_BITS_8;  // R7
                        end else begin
                            bitcnt_reg <= STXF_BITS_7;  // R7 R8
                        end
                        if (fmt.mp_mode) begin
                            extra_reg <= i_mp_bit;  // R14
                        end else if (fmt.chr7) begin
                            extra_reg <= fmt.par_odd ^ (^hold_reg[6:0]);  // R10
                        end else begin
                            extra_reg <= fmt.par_odd ^ (^hold_reg);  // R10 R11
                        end
                        stopcnt_reg <= fmt.stop2 ? STXF_STOP_2 : STXF_STOP_1;  // R12
                        state_reg <= fmt.sync_mode ? STXF_DATA : STXF_START;  // R6 R18
                    end
                end
                STXF_START: begin
                    if (bit_end) begin
                        state_reg <= STXF_DATA;
                    end
                end
                STXF_DATA: begin
                    if (bit_end) begin
                        shift_reg  <= {1'b0, shift_reg[7:1]};  // R16
                        bitcnt_reg <= bitcnt_reg - 4'h1;
                        if (bitcnt_reg == 4'h1) begin
                            if (fmt.sync_mode) begin
                                state_reg <= STXF_IDLE;  // R12
                            end else if (fmt.mp_mode || fmt.par_en) begin
                                state_reg <= STXF_EXTRA;  // R9 R14
                            end else begin
                                state_reg <= STXF_STOP;
                            end
                        end
                    end
                end
                STXF_EXTRA: begin
                    if (bit_end) begin
                        state_reg <= STXF_STOP;
                    end
                end
                STXF_STOP: begin
                    if (bit_end) begin
                        stopcnt_reg <= stopcnt_reg - 2'h1;
                        if (stopcnt_reg == 2'h1) begin
                            state_reg <= STXF_IDLE;  // R12
                        end
                    end
                end
                default: state_reg <= STXF_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // line drive: idle mark, registered so the pin never glitches
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_txd  <= 1'b1;
            o_sclk <= 1'b1;
        end else if (i_ce) begin
            case (state_reg)
                STXF_START: o_txd <= 1'b0;  // R18
                STXF_DATA:  o_txd <= shift_reg[0];  // R16
                STXF_EXTRA: o_txd <= extra_reg;  // R9
                default:    o_txd <= 1'b1;  // R12
            endcase
            // sync clock low during first half of each data bit; needs two ticks a bit
            o_sclk <= !(fmt.sync_mode && state_reg == STXF_DATA
                        && ticks_reg <= {1'b0, i_bit_ticks[7:1]});
        end
    end

endmodule : stxf_core

/* core/stxf_prescaler.sv */
// stxf_prescaler: peripheral clock prescaler for the baud generator input.
// assumes i_clk is the peripheral clock and i_ce gates all state.
`timescale 1ns/1ps
module stxf_prescaler
    import stxf_pkg::*;
(
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_srst,
    input  wire logic       i_ce,
    // selection
    input  wire logic [1:0] i_cks,
    // tick out
    output logic            o_tick
);

    logic [5:0] cnt_reg;
    logic [5:0] last;

    always_comb begin
        case (i_cks)
            2'h0:    last = STXF_DIV1_LAST;   // R15
            2'h1:    last = STXF_DIV4_LAST;   // R15
            2'h2:    last = STXF_DIV16_LAST;  // R15
            default: last = STXF_DIV64_LAST;  // R15
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cnt_reg <= 6'h00;
            o_tick  <= 1'b0;
        end else if (i_ce) begin
            // a selection change mid-count only stretches or shortens one period
            if (cnt_reg >= last) begin
                cnt_reg <= 6'h00;
                o_tick  <= 1'b1;
            end else begin
                cnt_reg <= cnt_reg + 6'h01;
                o_tick  <= 1'b0;
            end
        end
    end

endmodule : stxf_prescaler

/* dv/stxf_core_asserts.sv */
// stxf_core_asserts: port checks of the transmit block.
// assumes it is bound onto stxf_core, one clock domain.
`timescale 1ns/1ps
module stxf_chk
    import stxf_pkg::*;
(
    // clock and requests
    input wire logic          i_clk,
    input wire logic          i_srst,
    input wire logic          i_ce,
    input wire stxf_cpu_req_t i_cpu,
    input wire logic          i_clear_empty,
    input wire logic          i_tx_enable,
    // outputs
    input wire logic [7:0]    o_hold_rdata,
    input wire logic [7:0]    o_fmt_rdata,
    input wire logic          o_empty_flag,
    input wire logic          o_tx_busy,
    input wire logic          o_txd,
    input wire logic          o_sclk
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    wire logic hwr = i_ce && i_cpu.wr && i_cpu.sel == STXF_SEL_HOLD;
    wire logic fwr = i_ce && i_cpu.wr && i_cpu.sel == STXF_SEL_FORMAT;
    wire logic idle = o_empty_flag && !o_tx_busy;
    sequence s_no_hwr; !hwr [*2]; endsequence
    // three quiet cycles cover the clear-to-busy latency
    sequence s_no_clr; !i_clear_empty [*3]; endsequence
    sequence s_off; !i_tx_enable [*2]; endsequence
    property p_hold_wr; hwr |-> ##2 o_hold_rdata == $past(i_cpu.wdata, 2); endproperty
    a_hold_wr: assert property (p_hold_wr) else $error("hold write lost");
    property p_fmt_wr; fwr |-> ##2 o_fmt_rdata == $past(i_cpu.wdata, 2); endproperty
    a_fmt_wr: assert property (p_fmt_wr) else $error("format write lost");
    property p_hold_keep; s_no_hwr |=> $stable(o_hold_rdata); endproperty
    a_hold_keep: assert property (p_hold_keep) else $error("hold changed");
    property p_rst;
        $past(i_srst) |-> o_hold_rdata == STXF_HOLD_RST && o_fmt_rdata == STXF_FMT_RST;
    endproperty
    a_rst: assert property (p_rst) else $error("reset value wrong");
    property p_launch; i_ce && i_clear_empty && i_tx_enable && idle |-> ##3 o_tx_busy; endproperty
    a_launch: assert property (p_launch) else $error("no load");
    property p_no_load; s_no_clr ##0 idle |=> !o_tx_busy; endproperty
    a_no_load: assert property (p_no_load) else $error("load without data");
    property p_start; $rose(o_tx_busy) && !o_fmt_rdata[STXF_FMT_SYNC_BIT] |-> !o_txd; endproperty
    a_start: assert property (p_start) else $error("no start bit");
    property p_idle; !o_tx_busy |-> o_txd && o_sclk; endproperty
    a_idle: assert property (p_idle) else $error("line not idle");
    property p_off; s_off |=> o_empty_flag; endproperty
    a_off: assert property (p_off) else $error("empty not forced");
endmodule : stxf_chk

bind stxf_core stxf_chk chk_u (
    .i_clk         (i_clk),
    .i_srst        (i_srst),
    .i_ce          (i_ce),
    .i_cpu         (i_cpu),
    .i_clear_empty (i_clear_empty),
    .i_tx_enable   (i_tx_enable),
    .o_hold_rdata  (o_hold_rdata),
    .o_fmt_rdata   (o_fmt_rdata),
    .o_empty_flag  (o_empty_flag),
    .o_tx_busy     (o_tx_busy),
    .o_txd         (o_txd),
    .o_sclk        (o_sclk)
);

/* dv/stxf_rx_model.sv */
// stxf_rx_model: receiver on the far end of the serial line.
// assumes the bench sets frame length and bit time before each frame.
`timescale 1ns/1ps
module stxf_rx_model (
    // line
    input  wire logic       i_clk,
    input  wire logic       i_txd,
    input  wire logic       i_sclk,
    // framing
    input  wire logic       i_sync,
    input  wire logic [3:0] i_nbits,
    input  int              i_bit_cyc,
    // capture
    output logic [11:0]     o_frame,
    output int              o_count
);
    logic [11:0] a_frame = '0;
    logic [11:0] s_frame = '0;
    int          a_count = 0;
    int          s_count = 0;
    int          sbit = 0;
    // each mode keeps its own capture so every variable has a single writer
    assign o_frame = (i_sync === 1'b1) ? s_frame : a_frame;
    assign o_count = a_count + s_count;
    // sampling mid-bit tolerates a start bit shortened by prescaler phase
    always @(negedge i_txd) begin
        if (i_sync !== 1'b1) begin
            a_frame = '0;
            repeat (i_bit_cyc / 2) @(posedge i_clk);
            for (int k = 0; k < i_nbits; k++) begin
                if (k > 0) repeat (i_bit_cyc) @(posedge i_clk);
                a_frame[k] = i_txd;
            end
            a_count++;
        end
    end
    always @(posedge i_sclk) begin
        if (i_sync === 1'b1) begin
            if (sbit == 0) s_frame = '0;
            s_frame[sbit] = i_txd;
            sbit = (sbit + 1) % 8;
            if (sbit == 0) s_count++;
        end
    end
endmodule : stxf_rx_model

/* dv/tb_top.sv */
// tb_top: register and frame tests of the serial transmit block.
// assumes stxf_core as device and stxf_rx_model on its line.
`timescale 1ns/1ps
module tb_top;
    import stxf_pkg::*;
    logic          i_clk = 1'b0;
    logic          i_srst = 1'b1;
    logic          i_ce = 1'b1;
    logic          i_clear_empty = 1'b0;
    logic          i_tx_enable = 1'b1;
    logic          i_mp_bit = 1'b0;
    stxf_cpu_req_t i_cpu = '0;
    logic [7:0]    o_hold_rdata, o_fmt_rdata;
    logic          o_empty_flag, o_tx_busy, o_baud_tick, o_txd, o_sclk;
    logic [3:0]    nbits = 4'h0;
    logic [11:0]   frame;
    logic [7:0]    fmts [8] = '{8'h00, 8'h78, 8'h20, 8'h34, 8'h4d, 8'h12, 8'h0b, 8'hfe};
    int            bit_cyc = 4;
    int            count;
    int            err_total = 0;
    int            n_compared = 0;

    stxf_core dut_u (
        .i_clk         (i_clk),
        .i_srst        (i_srst),
        .i_ce          (i_ce),
        .i_cpu         (i_cpu),
        .i_clear_empty (i_clear_empty),
        .i_tx_enable   (i_tx_enable),
        .i_mp_bit      (i_mp_bit),
        .i_bit_ticks   (8'h03),
        .o_hold_rdata  (o_hold_rdata),
        .o_fmt_rdata   (o_fmt_rdata),
        .o_empty_flag  (o_empty_flag),
        .o_tx_busy     (o_tx_busy),
        .o_baud_tick   (o_baud_tick),
        .o_txd         (o_txd),
        .o_sclk        (o_sclk)
    );
    stxf_rx_model rx_u (.i_clk(i_clk), .i_txd(o_txd), .i_sclk(o_sclk),
        .i_sync(o_fmt_rdata[STXF_FMT_SYNC_BIT]), .i_nbits(nbits),
        .i_bit_cyc(bit_cyc), .o_frame(frame), .o_count(count));

    initial forever #12.5 i_clk = ~i_clk;

    task automatic end_sim();
        if (err_total == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [11:0] ex, input logic [11:0] got);
        n_compared++;
        if (ex !== got) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    task automatic wr(input logic s, input logic [7:0] d);
        i_cpu = '{1'b1, s, d};
        @(negedge i_clk);
        i_cpu.wr = 1'b0;
        // idle cycle so a following call never drives the strobe twice at once
        @(negedge i_clk);
    endtask : wr

    task automatic clr();
        i_clear_empty = 1'b1;
        @(negedge i_clk);
        i_clear_empty = 1'b0;
    endtask : clr

    task automatic rst();
        i_srst = 1'b1;
        repeat (20) @(negedge i_clk);
        i_srst = 1'b0;
        chk("hold reset", 12'(STXF_HOLD_RST), 12'(o_hold_rdata));
        chk("format reset", 12'(STXF_FMT_RST), 12'(o_fmt_rdata));
        chk("txd idle", 12'(1'b1), 12'(o_txd));
    endtask : rst

    // idle wait keeps a format write out of the last stop bit
    task automatic wait_frame(input int c0, input logic idle);
        int n = 0;
        while ((count == c0 || (idle && o_tx_busy !== 1'b0)) && n < 5000) begin
            @(negedge i_clk);
            n++;
        end
        if (n == 5000) begin
            chk("frame wait", 12'h000, 12'h001);
            end_sim();
        end
    endtask : wait_frame

    function automatic logic [11:0] expf(input logic [7:0] f, input logic [7:0] d);
        logic [11:0] e = '0;
        logic c7 = f[STXF_FMT_CHR7_BIT];
        nbits = 4'h8;
        if (f[STXF_FMT_SYNC_BIT]) return {4'h0, d};
        if (c7) d[7] = 1'b0;
        nbits = c7 ? 4'h8 : 4'h9;
        e[8:1] = d;
        if (f[STXF_FMT_MP_BIT]) e[nbits] = i_mp_bit;
        else if (f[STXF_FMT_PAREN_BIT]) e[nbits] = f[STXF_FMT_ODD_BIT] ^ (^d);
        if (f[STXF_FMT_MP_BIT] | f[STXF_FMT_PAREN_BIT]) nbits++;
        e[nbits] = 1'b1;
        if (f[STXF_FMT_STOP2_BIT]) begin
            nbits++;
            e[nbits] = 1'b1;
        end
        nbits++;
        return e;
    endfunction : expf

    initial begin
        logic [7:0] d;
        logic [11:0] e;
        int c0;
        int n;
        rst();
        foreach (fmts[k]) begin
            i_mp_bit = k[0];
            bit_cyc = 4 << (2 * fmts[k][1:0]);
            d = 8'hb5 + 8'(k * 29);
            e = expf(fmts[k], d);
            wr(STXF_SEL_FORMAT, fmts[k]);
            wr(STXF_SEL_HOLD, d);
            c0 = count;
            clr();
            wait_frame(c0, 1'b1);
            chk("frame", e, frame);
            chk("format", 12'(fmts[k]), 12'(o_fmt_rdata));
            chk("hold", 12'(d), 12'(o_hold_rdata));
        end
        wr(STXF_SEL_FORMAT, 8'h00);
        bit_cyc = 4;
        e = expf(8'h00, 8'h3c);
        wr(STXF_SEL_HOLD, 8'h3c);
        c0 = count;
        clr();
        repeat (2) @(negedge i_clk);
        chk("empty reload", 12'(1'b1), 12'(o_empty_flag));
        wr(STXF_SEL_HOLD, 8'hc3);
        clr();
        wait_frame(c0, 1'b0);
        chk("first frame", e, frame);
        wait_frame(c0 + 1, 1'b1);
        chk("second frame", expf(8'h00, 8'hc3), frame);
        wr(STXF_SEL_HOLD, 8'h81);
        n = 0;
        repeat (8) begin
            @(negedge i_clk);
            n += int'(o_baud_tick);
        end
        chk("baud ticks", 12'h002, 12'(n));
        chk("load without clear", 12'(1'b0), 12'(o_tx_busy));
        // a write while the clock enable is low must leave the buffer alone
        i_ce = 1'b0;
        wr(STXF_SEL_HOLD, 8'h55);
        i_ce = 1'b1;
        repeat (2) @(negedge i_clk);
        chk("hold frozen", 12'h081, 12'(o_hold_rdata));
        i_tx_enable = 1'b0;
        clr();
        repeat (8) @(negedge i_clk);
        chk("load disabled", 12'(1'b0), 12'(o_tx_busy));
        chk("empty disabled", 12'(1'b1), 12'(o_empty_flag));
        i_tx_enable = 1'b1;
        wr(STXF_SEL_FORMAT, 8'h5a);
        rst();
        end_sim();
    end
endmodule : tb_top

/* inc/stxf_pkg.sv */
// stxf_pkg: constants and types for the serial transmit buffer and frame format block.
// assumes a single peripheral clock domain; registers are reached by plain ports.
package stxf_pkg;

    // ------------------------------------------------------------------
    // register access codes and reset values
    // ------------------------------------------------------------------
    localparam logic [0:0] STXF_SEL_HOLD   = 1'h0;
    localparam logic [0:0] STXF_SEL_FORMAT = 1'h1;
    localparam logic [7:0] STXF_HOLD_RST   = 8'hff;
    localparam logic [7:0] STXF_FMT_RST    = 8'h00;

    // ------------------------------------------------------------------
    // frame format field positions
    // ------------------------------------------------------------------
    localparam int STXF_FMT_SYNC_BIT  = 7;
    localparam int STXF_FMT_CHR7_BIT  = 6;
    localparam int STXF_FMT_PAREN_BIT = 5;
    localparam int STXF_FMT_ODD_BIT   = 4;
    localparam int STXF_FMT_STOP2_BIT = 3;
    localparam int STXF_FMT_MP_BIT    = 2;
    localparam int STXF_FMT_CKS_HI    = 1;
    localparam int STXF_FMT_CKS_LO    = 0;

    // ------------------------------------------------------------------
    // prescaler terminal counts: divide by 1, 4, 16, 64
    // ------------------------------------------------------------------
    localparam logic [5:0] STXF_DIV1_LAST  = 6'h00;
    localparam logic [5:0] STXF_DIV4_LAST  = 6'h03;
    localparam logic [5:0] STXF_DIV16_LAST = 6'h0f;
    localparam logic [5:0] STXF_DIV64_LAST = 6'h3f;

    // ------------------------------------------------------------------
    // character bit counts and stop bit counts
    // ------------------------------------------------------------------
    localparam logic [3:0] STXF_BITS_8 = 4'h8;
    localparam logic [3:0] STXF_BITS_7 = 4'h7;
    localparam logic [1:0] STXF_STOP_1 = 2'h1;
    localparam logic [1:0] STXF_STOP_2 = 2'h2;

    typedef enum logic [2:0] {
        STXF_IDLE,
        STXF_START,
        STXF_DATA,
        STXF_EXTRA,
        STXF_STOP
    } stxf_state_t;

    // cpu register access group
    typedef struct packed {
        logic       wr;
        logic       sel;
        logic [7:0] wdata;
    } stxf_cpu_req_t;

    // decoded format fields
    typedef struct packed {
        logic       sync_mode;
        logic       chr7;
        logic       par_en;
        logic       par_odd;
        logic       stop2;
        logic       mp_mode;
        logic [1:0] cks;
    } stxf_fmt_t;

endpackage : stxf_pkg
